//--- pst_pkg.sv
// Purpose: Constants for the program-space table access datapath
// Assumes: 24-bit program words, 16-bit data words, byte select is address bit 0
// Notes:   Register offsets, op codes and field positions live here only
//
// Behaviour
// - Low table read/write reach program word bits 15..0 directly, not via data space.
// - Only the high table read/write touch program word bits 23..16.
// - Program addresses step by two per 24-bit word; word index is address bits above 0.
// - Program memory is two side-by-side 16-bit spaces; low ops low word, high ops top byte.
// - Every table read and write works in byte mode or 16-bit word mode.
// - Word-mode low read returns program bits 15..0 in data bits 15..0.
// - Byte-mode low read returns upper low-word byte if select is 1, else lower.
// - Word-mode high read returns bits 23..16 low, phantom upper byte always zero.
// - Byte-mode high read returns bits 23..16 if select is 0, zero if 1.
// - High and low table writes store bytes or words, mirroring the reads.
// - Every table access takes its region from the table page register.
// - Page bit 7 clear selects user space, set selects configuration space.

package pst_pkg;

  // Widths
  localparam int PAGE_W  = 8;
  localparam int EA_W    = 16;
  localparam int PWORD_W = 24;
  localparam int DATA_W  = 16;
  localparam int LANES   = 3;
  localparam int RADDR_W = 4;
  localparam int RDATA_W = 32;

  // Register offsets on the plain register port
  localparam logic [RADDR_W-1:0] OFF_PAGE   = 4'h0;
  localparam logic [RADDR_W-1:0] OFF_STATUS = 4'h4;

  // Reset values
  localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;

  // Field positions
  localparam int PAGE_CFG_BIT = 7;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_CFG     = 1;
  localparam int STAT_OP_LSB  = 2;
  localparam int BYTE_SEL_BIT = 0;

  // Table operation codes on the core request port
  localparam logic [1:0] OP_READ_LOW   = 2'h0;
  localparam logic [1:0] OP_READ_HIGH  = 2'h1;
  localparam logic [1:0] OP_WRITE_LOW  = 2'h2;
  localparam logic [1:0] OP_WRITE_HIGH = 2'h3;

  // Byte lane enables of a program word
  localparam logic [LANES-1:0] LANE_NONE = 3'h0;
  localparam logic [LANES-1:0] LANE_B0   = 3'h1;
  localparam logic [LANES-1:0] LANE_B1   = 3'h2;
  localparam logic [LANES-1:0] LANE_LOW  = 3'h3;
  localparam logic [LANES-1:0] LANE_HIGH = 3'h4;

  // Controller states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_CAPTURE,
    ST_ANSWER
  } pst_state_t;

endpackage : pst_pkg

//--- pst_table_access.sv
// Purpose: Table read/write datapath between the core and the program memory array
// Assumes: Memory returns read data the cycle after its read strobe, same clock
// Notes:   One access at a time; requests while not ready are ignored
//          Page is captured when a request is taken, so later page writes apply from the next access
//          A phantom-byte write still strobes memory, with no lane enabled
//
// Our own choices: the register addresses and the plain strobed port.

`timescale 1ns/1ps
`default_nettype none

module pst_table_access #(
  parameter int PAGE_W = pst_pkg::PAGE_W,
  parameter int EA_W   = pst_pkg::EA_W
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  // Register port
  input  wire logic [pst_pkg::RADDR_W-1:0] regAddr,
  input  wire logic [pst_pkg::RDATA_W-1:0] regWdata,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic      [pst_pkg::RDATA_W-1:0] regRdata,
  // Core request side
  input  wire logic                       reqValid,
  input  wire logic [1:0]                 reqOp,
  input  wire logic                       reqByteMode,
  input  wire logic [EA_W-1:0]            reqEa,
  input  wire logic [pst_pkg::DATA_W-1:0] reqWdata,
  output logic                            reqReady,
  output logic                            reqDone,
  output logic      [pst_pkg::DATA_W-1:0] rdData,
  // Program memory side
  output logic      [PAGE_W+EA_W-1:0]     memAddr,
  output logic                            memCfgSpace,
  output logic                            memRead,
  output logic                            memWrite,
  output logic      [pst_pkg::PWORD_W-1:0] memWdata,
  output logic      [pst_pkg::LANES-1:0]  memLane,
  input  wire logic [pst_pkg::PWORD_W-1:0] memRdata
);

  typedef struct packed {
    pst_pkg::pst_state_t         st;
    logic [PAGE_W-1:0]           page;
    logic [1:0]                  op;
    logic                        byteMode;
    logic [PAGE_W+EA_W-1:0]      addr;
    logic                        cfg;
    logic                        rd;
    logic                        wr;
    logic [pst_pkg::PWORD_W-1:0] wdata;
    logic [pst_pkg::LANES-1:0]   lane;
    logic [pst_pkg::DATA_W-1:0]  rdOut;
    logic                        done;
    logic                        ready;
    logic [pst_pkg::RDATA_W-1:0] regOut;
  } pst_regs_t;

  pst_regs_t state_reg;
  pst_regs_t state_next;
  logic      rstMeta_reg;
  logic      rstSync_reg;

  // Shapes a program word into the data word a table read returns
  function automatic logic [pst_pkg::DATA_W-1:0] readShape(
    input logic [1:0]                  op,
    input logic                        byteMode,
    input logic                        byteSel,
    input logic [pst_pkg::PWORD_W-1:0] word
  );
    logic [pst_pkg::DATA_W-1:0] res;
    res = 16'h0000;
    if (op == pst_pkg::OP_READ_LOW) begin
      if (!byteMode) begin
        res = word[15:0];
      end else if (byteSel) begin
        res = {8'h00, word[15:8]};
      end else begin
        res = {8'h00, word[7:0]};
      end
    end else begin
      if (!byteMode) begin
        res = {8'h00, word[23:16]};
      end else if (!byteSel) begin
        res = {8'h00, word[23:16]};
      end else begin
        res = 16'h0000;
      end
    end
    return res;
  endfunction

  // Lane enables for a table write, mirroring the read selection
  function automatic logic [pst_pkg::LANES-1:0] writeLanes(
    input logic [1:0] op,
    input logic       byteMode,
    input logic       byteSel
  );
    logic [pst_pkg::LANES-1:0] res;
    res = pst_pkg::LANE_NONE;
    if (op == pst_pkg::OP_WRITE_LOW) begin
      if (!byteMode) begin
        res = pst_pkg::LANE_LOW;
      end else if (byteSel) begin
        res = pst_pkg::LANE_B1;
      end else begin
        res = pst_pkg::LANE_B0;
      end
    end else if (!byteMode || !byteSel) begin
      res = pst_pkg::LANE_HIGH;
    end
    return res;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // Next-state logic for registers, request sequencing and memory strobes
  always_comb begin
    logic bsel;
    bsel = reqEa[pst_pkg::BYTE_SEL_BIT];
    state_next = state_reg;
    state_next.rd = 1'b0;
    state_next.wr = 1'b0;
    state_next.done = 1'b0;
    state_next.regOut = 32'h0000_0000;

    // Page register write and register reads
    if (regWrite && regAddr == pst_pkg::OFF_PAGE) begin
      state_next.page = regWdata[PAGE_W-1:0];
    end
    if (regRead) begin
      unique case (regAddr)
        pst_pkg::OFF_PAGE: begin
          state_next.regOut[PAGE_W-1:0] = state_reg.page;
        end
        pst_pkg::OFF_STATUS: begin
          state_next.regOut[pst_pkg::STAT_BUSY] = !state_reg.ready;
          state_next.regOut[pst_pkg::STAT_CFG] = state_reg.cfg;
          state_next.regOut[pst_pkg::STAT_OP_LSB +: 2] = state_reg.op;
        end
        default: begin
          state_next.regOut = 32'h0000_0000;
        end
      endcase
    end

    unique case (state_reg.st)
      // Take a request only while idle; page and select are captured here
      pst_pkg::ST_IDLE: begin
        if (reqValid) begin
          state_next.op = reqOp;
          state_next.byteMode = reqByteMode;
          state_next.addr = {state_reg.page, reqEa};
          state_next.cfg = state_reg.page[pst_pkg::PAGE_CFG_BIT];
          state_next.ready = 1'b0;
          state_next.st = pst_pkg::ST_ISSUE;
          if (reqOp[1]) begin
            // Writes go out in one cycle and finish at once
            state_next.wr = 1'b1;
            state_next.done = 1'b1;
            state_next.lane = writeLanes(reqOp, reqByteMode, bsel);
            state_next.wdata = {reqWdata[7:0], 16'h0000};
            if (!reqOp[0]) begin
              state_next.wdata = bsel && reqByteMode ?
                {8'h00, reqWdata[7:0], 8'h00} :
                {8'h00, reqByteMode ? {8'h00, reqWdata[7:0]} : reqWdata};
            end
          end else begin
            state_next.rd = 1'b1;
            state_next.lane = pst_pkg::LANE_NONE;
          end
        end
      end
      pst_pkg::ST_ISSUE: begin
        // Write done, or read strobe just out
        if (state_reg.op[1]) begin
          state_next.st = pst_pkg::ST_IDLE;
          state_next.ready = 1'b1;
        end else begin
          state_next.st = pst_pkg::ST_CAPTURE;
        end
      end
      pst_pkg::ST_CAPTURE: begin
        // Memory word stands only now; shape it before it turns invalid
        state_next.rdOut = readShape(state_reg.op, state_reg.byteMode,
                                     state_reg.addr[pst_pkg::BYTE_SEL_BIT], memRdata);
        state_next.done = 1'b1;
        state_next.st = pst_pkg::ST_ANSWER;
      end
      pst_pkg::ST_ANSWER: begin
        // Answer has been shown for one cycle; accept again
        state_next.st = pst_pkg::ST_IDLE;
        state_next.ready = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      state_reg <= '{st: pst_pkg::ST_IDLE, page: pst_pkg::PAGE_RESET,
                     op: pst_pkg::OP_READ_LOW, byteMode: 1'b0, addr: '0,
                     cfg: 1'b0, rd: 1'b0, wr: 1'b0, wdata: 24'h00_0000,
                     lane: pst_pkg::LANE_NONE,
                     rdOut: 16'h0000, done: 1'b0, ready: 1'b1,
                     regOut: 32'h0000_0000};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flip-flops
  assign regRdata    = state_reg.regOut;
  assign reqReady    = state_reg.ready;
  assign reqDone     = state_reg.done;
  assign rdData      = state_reg.rdOut;
  assign memAddr     = state_reg.addr;
  assign memCfgSpace = state_reg.cfg;
  assign memRead     = state_reg.rd;
  assign memWrite    = state_reg.wr;
  assign memWdata    = state_reg.wdata;
  assign memLane     = state_reg.lane;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstSync_reg);

  // Read strobe carries page over effective address
  AST_READ_ADDR: assert property (
    reqReady && reqValid && !reqOp[1] |=>
      memRead && memAddr == {$past(state_reg.page), $past(reqEa)})
    else $error("Table read address not page over effective address");

  // Space select follows page bit seven at accept
  AST_CFG_SPACE: assert property (
    reqReady && reqValid |=> memCfgSpace == $past(state_reg.page[pst_pkg::PAGE_CFG_BIT]))
    else $error("Space select does not follow page bit seven");

  // Write strobe lasts one cycle, with its done pulse in the same cycle
  AST_WRITE_PULSE: assert property (
    reqReady && reqValid && reqOp[1] |=> memWrite && !memRead && reqDone ##1 !memWrite)
    else $error("Table write strobe not a single pulse");

  // Read answer comes two cycles after the strobe, then ready again
  AST_READ_ANSWER: assert property (
    memRead |-> !reqDone ##1 !reqDone ##1 reqDone ##1 !reqDone && reqReady)
    else $error("Table read answer not two cycles after strobe");

  // Word-mode low read copies the low program word
  AST_LOW_WORD: assert property (
    memRead && state_reg.op == pst_pkg::OP_READ_LOW && !state_reg.byteMode
      ##1 1'b1 |=> rdData == $past(memRdata[15:0]))
    else $error("Low word read mismatch");

  // Byte-mode low read picks a byte by select
  AST_LOW_BYTE: assert property (
    memRead && state_reg.op == pst_pkg::OP_READ_LOW && state_reg.byteMode
      ##1 1'b1 |=> rdData == {8'h00, memAddr[0] ? $past(memRdata[15:8])
                                               : $past(memRdata[7:0])})
    else $error("Low byte read selected wrong byte");

  // Phantom byte of a high read is always zero
  AST_PHANTOM: assert property (
    memRead && state_reg.op == pst_pkg::OP_READ_HIGH ##2 reqDone |->
      rdData[15:8] == 8'h00)
    else $error("Phantom byte not zero");

  // Phantom byte selected in byte mode reads zero
  AST_HIGH_BYTE: assert property (
    memRead && state_reg.op == pst_pkg::OP_READ_HIGH && state_reg.byteMode && memAddr[0]
      ##2 reqDone |-> rdData == 16'h0000)
    else $error("High byte read of phantom not zero");

  // High writes touch only the top lane, or none for the phantom byte
  AST_HIGH_LANE: assert property (
    memWrite |-> (state_reg.op[0] ? memLane[1:0] == 2'h0
                                  : (!memLane[2] && memLane != pst_pkg::LANE_NONE)))
    else $error("Write lanes do not match low or high op");

  // Page register takes the written low byte
  AST_PAGE_LOAD: assert property (
    regWrite && regAddr == pst_pkg::OFF_PAGE |=> state_reg.page == $past(regWdata[PAGE_W-1:0]))
    else $error("Page register not loaded");

  // Page reads back on the register port the cycle after the strobe
  AST_PAGE_READ: assert property (
    regRead && regAddr == pst_pkg::OFF_PAGE |=> regRdata[PAGE_W-1:0] == $past(state_reg.page))
    else $error("Page register read back wrong");

  // Word-mode high read: upper program byte low, phantom byte zero
  AST_HIGH_WORD: assert property (
    memRead && state_reg.op == pst_pkg::OP_READ_HIGH && !state_reg.byteMode
      ##1 1'b1 |=> rdData == {8'h00, $past(memRdata[23:16])})
    else $error("High word read mismatch");

  // Byte-mode high read with select clear returns the upper program byte
  AST_HIGH_SEL0: assert property (
    memRead && state_reg.op == pst_pkg::OP_READ_HIGH && state_reg.byteMode && !memAddr[0]
      ##1 1'b1 |=> rdData[7:0] == $past(memRdata[23:16]))
    else $error("High byte read of upper byte mismatch");

  // Word-mode low write fills both low lanes with the request data
  AST_LOW_WR_WORD: assert property (
    memWrite && state_reg.op == pst_pkg::OP_WRITE_LOW && !state_reg.byteMode |->
      memLane == pst_pkg::LANE_LOW && memWdata[15:0] == $past(reqWdata))
    else $error("Low word write lanes or data wrong");

  // Byte-mode low write puts the data byte in the selected lane only
  AST_LOW_BYTE_WR: assert property (
    memWrite && state_reg.op == pst_pkg::OP_WRITE_LOW && state_reg.byteMode |->
      memLane == (memAddr[0] ? pst_pkg::LANE_B1 : pst_pkg::LANE_B0) &&
      (memAddr[0] ? memWdata[15:8] : memWdata[7:0]) == $past(reqWdata[7:0]))
    else $error("Low byte write lane or data wrong");

  // High write of the real byte lands in the top lane
  AST_HIGH_WR_DATA: assert property (
    memWrite && state_reg.op == pst_pkg::OP_WRITE_HIGH && memLane != pst_pkg::LANE_NONE |->
      memLane == pst_pkg::LANE_HIGH && memWdata[23:16] == $past(reqWdata[7:0]))
    else $error("High byte write lane or data wrong");

  // Read strobe is one cycle and never beside a write strobe
  AST_READ_PULSE: assert property (
    memRead |-> !memWrite ##1 !memRead)
    else $error("Read strobe not a single pulse");

  // While busy no new memory strobe is started
  AST_BUSY_QUIET: assert property (
    !reqReady |=> !memRead && !memWrite)
    else $error("Memory strobe while busy");

  // Main scenarios
  COV_READ_LOW:  cover property (memRead && state_reg.op == pst_pkg::OP_READ_LOW ##2 reqDone);
  COV_READ_HIGH: cover property (memRead && state_reg.op == pst_pkg::OP_READ_HIGH ##2 reqDone);
  COV_WRITE_CFG: cover property (memWrite && memCfgSpace);
  COV_BYTE_WR:   cover property (memWrite && state_reg.byteMode);
  COV_PHANTOM_WR: cover property (memWrite && memLane == pst_pkg::LANE_NONE);

endmodule // pst_table_access

`default_nettype wire

//--- pst_mem_model.sv
// Purpose: Behavioural program memory array that faces the table access block
// Assumes: Read word is presented only in the cycle after the read strobe
// Notes:   32 words, indexed by space select and word address bits 4:1

`timescale 1ns/1ps
`default_nettype none

module pst_mem_model (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [23:0] memAddr,
  input  wire logic        memCfgSpace,
  input  wire logic        memRead,
  input  wire logic        memWrite,
  input  wire logic [23:0] memWdata,
  input  wire logic [2:0]  memLane,
  output logic      [23:0] memRdata
);
  logic [23:0] memArr [0:31];
  logic [23:0] lastReg;
  logic        validReg;
  logic [4:0]  idx;

  // Word index skips address bit 0; space select picks the upper half
  assign idx = {memCfgSpace, memAddr[4:1]};

  // Known fill pattern at reset, then byte-lane writes and one-cycle reads
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      validReg <= 1'b0;
      lastReg  <= 24'h000000;
      for (int i = 0; i < 32; i++) memArr[i] <= {3{i[7:0]}} ^ 24'hC35A96;
    end else begin
      validReg <= memRead;
      if (memRead) lastReg <= memArr[idx];
      if (memWrite) begin
        for (int b = 0; b < 3; b++) begin
          if (memLane[b]) memArr[idx][8*b +: 8] <= memWdata[8*b +: 8];
        end
      end
    end
  end

  // Outside the answer cycle the lines carry the inverse, never a stale match
  assign memRdata = validReg ? lastReg : ~lastReg;
endmodule // pst_mem_model

`default_nettype wire

//--- pst_table_access_test.sv
// Purpose: Self-checking bench for the table access datapath
// Assumes: Memory partner answers one cycle after its read strobe
// Notes:   A shadow copy of the array predicts every read-back

`timescale 1ns/1ps
`default_nettype none

module pst_table_access_test;
  logic mclk = 1'b0, rst_b = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic reqValid = 1'b0, reqByteMode = 1'b0, reqReady, reqDone, memCfgSpace, memRead, memWrite;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic [1:0] reqOp = 2'h0;
  logic [15:0] reqEa = 16'h0, reqWdata = 16'h0, rdData;
  logic [23:0] memAddr, memWdata, memRdata;
  logic [2:0] memLane;
  logic [23:0] shadow [0:31];
  logic [7:0] curPage;
  int numErrors = 0, cmpCount = 0, cycles = 0;

  pst_table_access DUT (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .reqValid(reqValid),
    .reqOp(reqOp), .reqByteMode(reqByteMode), .reqEa(reqEa), .reqWdata(reqWdata),
    .reqReady(reqReady), .reqDone(reqDone), .rdData(rdData), .memAddr(memAddr),
    .memCfgSpace(memCfgSpace), .memRead(memRead), .memWrite(memWrite),
    .memWdata(memWdata), .memLane(memLane), .memRdata(memRdata));

  pst_mem_model MEM (.mclk(mclk), .rst_b(rst_b), .memAddr(memAddr), .memCfgSpace(memCfgSpace),
    .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata), .memLane(memLane),
    .memRdata(memRdata));

  // Clock and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      numErrors++;
      reportAndStop();
    end
  end

  task automatic reportAndStop();
    $display("Comparisons %0d, mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Masked comparison of any result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    cmpCount++;
    if ((got & m) !== (exp & m)) begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, got & m, exp & m);
    end
  endtask

  task automatic regWr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  task automatic regRd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    chk(regRdata, exp, m);
    @(negedge mclk);
    chk(regRdata, 32'h0, 32'hFFFFFFFF);
  endtask

  task automatic setPage(input logic [7:0] p);
    regWr(pst_pkg::OFF_PAGE, {24'h0, p});
    curPage = p;
    regRd(pst_pkg::OFF_PAGE, {24'h0, p}, 32'hFF);
  endtask

  // One table access; predicts strobes, lanes, address and read result
  task automatic tbl(input logic [1:0] op, input logic bm, input logic [15:0] ea,
                     input logic [15:0] wd);
    logic [4:0] ix;
    logic [2:0] ln;
    logic [23:0] w, d, m;
    logic [15:0] e;
    int n;
    ix = {curPage[7], ea[4:1]};
    w = shadow[ix];
    ln = (op == pst_pkg::OP_WRITE_LOW) ? (bm ? (ea[0] ? 3'h2 : 3'h1) : 3'h3)
                                       : ((bm && ea[0]) ? 3'h0 : 3'h4);
    d = {wd[7:0], bm ? {wd[7:0], wd[7:0]} : wd};
    m = {{8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
    e = (op == pst_pkg::OP_READ_LOW) ? (bm ? {8'h00, ea[0] ? w[15:8] : w[7:0]} : w[15:0])
                                     : ((bm && ea[0]) ? 16'h0000 : {8'h00, w[23:16]});
    @(posedge mclk);
    reqValid <= 1'b1;
    reqOp <= op;
    reqByteMode <= bm;
    reqEa <= ea;
    reqWdata <= wd;
    @(posedge mclk);
    reqValid <= 1'b0;
    @(negedge mclk);
    chk({8'h0, memAddr}, {8'h0, curPage, ea}, 32'hFFFFFF);
    chk({31'h0, memCfgSpace}, {31'h0, curPage[7]}, 32'h1);
    chk({31'h0, reqReady}, 32'h0, 32'h1);
    if (op[1]) begin
      chk({memRead, memWrite, reqDone}, 3'b011, 32'h7);
      chk({29'h0, memLane}, {29'h0, ln}, 32'h7);
      chk({8'h0, memWdata}, {8'h0, d}, {8'h0, m});
      shadow[ix] = (w & ~m) | (d & m);
    end else begin
      chk({memRead, memWrite}, 2'b10, 32'h3);
      n = 0;
      while (reqDone !== 1'b1 && n < 8) begin
        @(negedge mclk);
        n++;
      end
      chk(n, 2, 32'hF);
      chk({16'h0, rdData}, {16'h0, e}, bm ? 32'hFF : 32'hFFFF);
    end
  endtask

  initial begin
    for (int i = 0; i < 32; i++) shadow[i] = {3{i[7:0]}} ^ 24'hC35A96;
    curPage = 8'h00;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    // Reset values, unmapped and read-only places
    regRd(pst_pkg::OFF_PAGE, {24'h0, pst_pkg::PAGE_RESET}, 32'hFF);
    regWr(4'h8, 32'hFF);
    regRd(4'h8, 32'h0, 32'hFFFFFFFF);
    regWr(pst_pkg::OFF_STATUS, 32'hF);
    regRd(pst_pkg::OFF_STATUS, 32'h0, 32'hF);
    $display("Test registers done");
    // Every read kind, mode and byte select
    setPage(8'h01);
    for (int o = 0; o < 2; o++)
      for (int b = 0; b < 2; b++)
        for (int s = 0; s < 2; s++) tbl(o[1:0], b[0], 16'h0004 | s[15:0], 16'h0);
    regRd(pst_pkg::OFF_STATUS, 32'h4, 32'hF);
    $display("Test reads done");
    // Back-to-back writes of every shape, phantom byte included, then read back
    tbl(2'h2, 1'b0, 16'h0010, 16'hBEEF);
    tbl(2'h2, 1'b1, 16'h0012, 16'h0011);
    tbl(2'h2, 1'b1, 16'h0013, 16'h0022);
    tbl(2'h3, 1'b0, 16'h0014, 16'h0033);
    tbl(2'h3, 1'b1, 16'h0016, 16'h0044);
    tbl(2'h3, 1'b1, 16'h0017, 16'h0055);
    for (int a = 16'h10; a < 16'h18; a += 2) begin
      tbl(2'h0, 1'b0, a[15:0], 16'h0);
      tbl(2'h1, 1'b0, a[15:0], 16'h0);
    end
    $display("Test writes done");
    // Configuration space is separate from user space
    setPage(8'h81);
    tbl(2'h2, 1'b0, 16'h0010, 16'h1234);
    tbl(2'h0, 1'b0, 16'h0010, 16'h0);
    regRd(pst_pkg::OFF_STATUS, 32'h2, 32'hF);
    setPage(8'h01);
    tbl(2'h0, 1'b0, 16'h0010, 16'h0);
    $display("Test config space done");
    reportAndStop();
  end
endmodule // pst_table_access_test

`default_nettype wire
